// ===== bench/gpib_service_request_status_test.sv
/*
 self-checking bench for the service-request block.
 assumes the controller model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module gpib_service_request_status_test;
    import srs_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    srs_events_t events = '0;
    logic averaging_accessory = 1'b1;
    logic idle_alt_sel = 1'b0;
    logic auto_poll = 1'b0;
    logic poll_req = 1'b0;
    logic clear_req = 1'b0;
    srs_ctrl_t ctrl;
    logic srq;
    logic poll_valid;
    logic overflow;
    logic [7:0] poll_byte;
    int miscompares = 0;
    int total_checks = 0;
    // codes for recover, button, sweep, abort, comm, prog, int, other
    logic [7:0] codes [8] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h71, 8'h72, 8'h73, 8'h70};
    // 50 MHz
    always #10 core_clk = ~core_clk;
    srs_service_request u_dut (.core_clk(core_clk), .reset(reset), .events(events),
        .averaging_accessory(averaging_accessory), .idle_alt_sel(idle_alt_sel),
        .ctrl(ctrl), .srq(srq), .poll_byte(poll_byte), .poll_valid(poll_valid),
        .overflow(overflow));
    srs_ctrl_model u_ctrl (.core_clk(core_clk), .reset(reset), .auto_poll(auto_poll),
        .poll_req(poll_req), .clear_req(clear_req), .srq(srq), .ctrl(ctrl));
    task automatic report_and_stop();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check8(string name, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check1(string name, logic exp, logic got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask
    // one poll (0) or clear (1) through the controller model
    task automatic do_cmd(logic clr);
        @(negedge core_clk);
        if (clr) clear_req <= 1'b1;
        else poll_req <= 1'b1;
        @(negedge core_clk);
        poll_req <= 1'b0;
        clear_req <= 1'b0;
    endtask
    // bounded waits; the answer carries the word and srq is down by then
    task automatic wait_word(logic [7:0] exp);
        for (int n = 0; n < 20 && poll_valid !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        check1("poll_valid", 1'b1, poll_valid);
        check8("poll_byte", exp, poll_byte);
        check1("srq", 1'b0, srq);
    endtask
    task automatic wait_srq();
        for (int n = 0; n < 20 && srq !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        check1("srq", 1'b1, srq);
    endtask
    task automatic fire(logic [8:0] ev);
        @(negedge core_clk);
        events <= ev;
        @(negedge core_clk);
        events <= '0;
    endtask
    task automatic t_powerup();
        wait_srq();
        do_cmd(1'b0);
        wait_word(8'h51);
    endtask
    task automatic t_idle();
        for (int i = 1; i >= 0; i--) begin
            @(negedge core_clk);
            idle_alt_sel <= i[0];
            do_cmd(1'b0);
            wait_word(i[0] ? 8'h10 : 8'h00);
        end
    endtask
    // prompt controller polls each request as it appears
    task automatic t_events();
        auto_poll <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            fire(9'h100 >> i);
            wait_word(codes[i]);
        end
        // no auto poll here, so a wrongly taken abort would leave srq up
        auto_poll <= 1'b0;
        @(negedge core_clk);
        averaging_accessory <= 1'b0;
        fire(9'h020);
        repeat (8) @(posedge core_clk);
        #1;
        check1("srq", 1'b0, srq);
        @(negedge core_clk);
        averaging_accessory <= 1'b1;
    endtask
    // slow controller: two requests wait, reported in arrival order
    task automatic t_queue();
        fire(9'h080);
        fire(9'h040);
        for (int i = 1; i < 3; i++) begin
            wait_srq();
            do_cmd(1'b0);
            wait_word(codes[i]);
        end
    endtask
    // full queue plus one more, then a clear drops backlog, overflow and request
    task automatic t_clear();
        for (int i = 0; i < 9; i++) begin
            fire(9'h100 >> (i % 8));
        end
        wait_srq();
        check1("overflow", 1'b1, overflow);
        do_cmd(1'b1);
        @(posedge core_clk);
        #1;
        check1("srq", 1'b0, srq);
        check1("overflow", 1'b0, overflow);
        do_cmd(1'b0);
        wait_word(8'h00);
        repeat (4) @(posedge core_clk);
        #1;
        check1("srq", 1'b0, srq);
    endtask
    // main sequence after five reset cycles
    initial begin
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        t_powerup();
        t_idle();
        t_events();
        t_queue();
        t_clear();
        report_and_stop();
    end
    // watchdog well past the expected run of under a hundred cycles
    initial begin
        #50us;
        miscompares++;
        report_and_stop();
    end
endmodule
bind srs_service_request srs_sr_asserts u_chk (.core_clk(core_clk), .reset(reset),
    .events(events), .averaging_accessory(averaging_accessory),
    .idle_alt_sel(idle_alt_sel), .ctrl(ctrl), .srq(srq), .poll_byte(poll_byte),
    .poll_valid(poll_valid), .overflow(overflow));
`default_nettype wire

// ===== bench/srs_ctrl_model.sv
/*
 system controller model: serial polls and device clears on command.
 assumes bench commands change on the falling edge, one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module srs_ctrl_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // bench commands and device request
    input wire logic auto_poll,
    input wire logic poll_req,
    input wire logic clear_req,
    input wire logic srq,
    // strobes to the device
    output var srs_pkg::srs_ctrl_t ctrl
);
    import srs_pkg::*;
    // strobes one cycle wide; auto mode skips a second poll while srq settles
    always_ff @(negedge core_clk) begin
        if (reset) begin
            ctrl <= '0;
        end else begin
            ctrl.poll <= poll_req || (auto_poll && srq && !ctrl.poll);
            ctrl.interface_clear_command <= clear_req;
        end
    end
endmodule
`default_nettype wire

// ===== bench/srs_sr_asserts.sv
/*
 checker for the service-request block: srq, poll answer and status word.
 assumes a bind from the bench top; sees only the top module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module srs_sr_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // inputs watched
    input wire srs_pkg::srs_events_t events,
    input wire logic averaging_accessory,
    input wire logic idle_alt_sel,
    input wire srs_pkg::srs_ctrl_t ctrl,
    // outputs watched
    input wire logic srq,
    input wire logic [7:0] poll_byte,
    input wire logic poll_valid,
    input wire logic overflow
);
    import srs_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // a poll that no clear overrides; clear wins a tie
    sequence s_poll;
        ctrl.poll && !ctrl.interface_clear_command;
    endsequence
    // a poll seen while a request is up
    sequence s_poll_pending;
        s_poll ##0 srq;
    endsequence
    power_up_srq_a: assert property ($fell(reset) |-> ##[1:6] srq)
        else $error("no request after power up");
    poll_answer_a: assert property (s_poll |=> poll_valid)
        else $error("poll not answered");
    answer_cause_a: assert property (poll_valid |-> $past(ctrl.poll))
        else $error("answer without a poll");
    poll_release_a: assert property (s_poll_pending |=> !srq)
        else $error("request kept after poll");
    clear_drop_a: assert property (ctrl.interface_clear_command |=> !srq && !poll_valid)
        else $error("request kept after clear");
    idle_word_a: assert property (s_poll ##0 !srq |=>
        poll_byte == ($past(idle_alt_sel) ? 8'h10 : 8'h00))
        else $error("idle word wrong");
    rqs_bit_a: assert property (s_poll_pending |=> poll_byte[6])
        else $error("request bit missing");
    word_hold_a: assert property (!poll_valid |-> $stable(poll_byte))
        else $error("status word moved without poll");
    valid_pulse_a: assert property (poll_valid && !ctrl.poll |=> !poll_valid)
        else $error("answer strobe too long");
    overflow_clear_a: assert property (ctrl.interface_clear_command |=> !overflow)
        else $error("overflow kept after clear");
endmodule
`default_nettype wire

// ===== rtl/srs_params.svh
/*
 service-request status block: offsets-free constants (status codes, depths).
 assumes inclusion by the package and the design modules only.
*/
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH
`define SRS_CODE_IDLE 8'h00
`define SRS_CODE_IDLE_ALT 8'h10
`define SRS_CODE_POWERUP 8'h51
`define SRS_CODE_RECOVER 8'h52
`define SRS_CODE_BUTTON 8'h53
`define SRS_CODE_SWEEP 8'h54
`define SRS_CODE_AVG_ABORT 8'h55
`define SRS_CODE_ERR_OTHER 8'h70
`define SRS_CODE_ERR_COMM 8'h71
`define SRS_CODE_ERR_PROG 8'h72
`define SRS_CODE_ERR_INT 8'h73
`define SRS_RQS_BIT 6
`define SRS_QUEUE_DEPTH 8
`define SRS_NUM_EVENTS 9
`endif

// ===== rtl/srs_pkg.sv
/*
 types shared by the service-request status block.
 assumes srs_params.svh on the include path.
*/
`default_nettype none
`include "srs_params.svh"
package srs_pkg;
    // one pulse per reportable condition, in fixed priority order
    typedef struct packed {
        logic recover;
        logic button;
        logic sweep;
        logic avg_abort;
        logic err_comm;
        logic err_prog;
        logic err_int;
        logic err_other;
        logic spare;
    } srs_events_t;
    // serial poll and interface clear strobes from the bus-side state logic
    typedef struct packed {
        logic poll;
        logic interface_clear_command;
    } srs_ctrl_t;
    typedef enum logic [2:0] {
        SRS_ST_IDLE = 3'b001,
        SRS_ST_PEND = 3'b010,
        SRS_ST_POLLED = 3'b100
    } srs_state_t;
endpackage
`default_nettype wire

// ===== rtl/srs_queue.sv
/*
 small fifo holding status codes awaiting report.
 assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srs_params.svh"
module srs_queue #(
    parameter int DEPTH = `SRS_QUEUE_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // flush on device clear
    input wire logic flush,
    // write side
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    // read side
    input wire logic rd_take,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [7:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic do_wr;
    logic do_rd;

    assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid = (cnt_q != '0);
    assign rd_data = mem_q[rp_q];
    assign do_wr = wr_valid && wr_ready;
    assign do_rd = rd_take && rd_valid;

    // storage; no reset needed on data
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem_q[wp_q] <= wr_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge core_clk) begin
        if (reset || flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (do_rd) begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule
`default_nettype wire

// ===== rtl/srs_service_request.sv
/*
 service-request and serial-poll status word logic of a bus talker/listener.
 assumes poll and device-clear strobes are one-cycle pulses on core_clk from
 the bus protocol logic; event pulses come from instrument logic on core_clk.
*/
// Overview of operation
// - power-on raises a service request on its own, no command needed
// - a serial poll drops the pending request and reports its cause
// - unserviced request is dropped by the interface clear command
// - status word is returned on every poll that no clear overrides, request pending or not
// - idle poll returns zero or sixteen, both meaning idle
// - each reportable condition raises its own service request
// - power-up request reports 81
// - self-recovery after a hang reports 82
// - program-call button reports 83
// - single-sweep completion reports 84
// - fitted averaging accessory abort reports 85
// - each of four error classes is signalled with its own code
// - communication error reports 113
// - programming error reports 114
// - internal hardware error reports 115
// - any other error reports 112
// - full service request, no parallel poll; serial poll is the only path
`timescale 1ns/1ps
`default_nettype none
`include "srs_params.svh"
module srs_service_request #(
    parameter int DEPTH = `SRS_QUEUE_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // instrument events, one-cycle pulses
    input wire srs_pkg::srs_events_t events,
    input wire logic averaging_accessory,
    input wire logic idle_alt_sel,
    // bus control strobes
    input wire srs_pkg::srs_ctrl_t ctrl,
    // bus side
    output logic srq,
    output logic [7:0] poll_byte,
    output logic poll_valid,
    output logic overflow
);
    import srs_pkg::*;

    localparam int NE = `SRS_NUM_EVENTS;

    logic [NE-1:0] pend_q;
    logic [NE-1:0] pend_d;
    logic [NE-1:0] grant;
    logic [7:0] codes [NE];
    logic [7:0] enq_code;
    logic enq_valid;
    logic enq_ready;
    logic q_valid;
    logic [7:0] q_data;
    logic q_take;
    logic pwr_done_q;
    logic srq_q;
    logic [7:0] poll_byte_q;
    logic poll_valid_q;
    logic overflow_q;
    logic [7:0] cur_code_q;
    logic [7:0] idle_word;
    srs_state_t state_q;

    // code table in event-vector bit order, index 0 is power-up
    assign codes[0] = `SRS_CODE_POWERUP;
    assign codes[1] = `SRS_CODE_ERR_OTHER;
    assign codes[2] = `SRS_CODE_ERR_INT;
    assign codes[3] = `SRS_CODE_ERR_PROG;
    assign codes[4] = `SRS_CODE_ERR_COMM;
    assign codes[5] = `SRS_CODE_AVG_ABORT;
    assign codes[6] = `SRS_CODE_SWEEP;
    assign codes[7] = `SRS_CODE_BUTTON;
    assign codes[8] = `SRS_CODE_RECOVER;

    assign idle_word = idle_alt_sel ? `SRS_CODE_IDLE_ALT : `SRS_CODE_IDLE;

    // raw request vector: bit 0 is the power-up request, the spare bit is unused
    always_comb begin
        pend_d = pend_q;
        if (!pwr_done_q) begin
            pend_d[0] = 1'b1;
        end
        pend_d[1] = pend_d[1] | events.err_other;
        pend_d[2] = pend_d[2] | events.err_int;
        pend_d[3] = pend_d[3] | events.err_prog;
        pend_d[4] = pend_d[4] | events.err_comm;
        // abort only counts with the accessory fitted
        pend_d[5] = pend_d[5] | (events.avg_abort & averaging_accessory);
        pend_d[6] = pend_d[6] | events.sweep;
        pend_d[7] = pend_d[7] | events.button;
        pend_d[8] = pend_d[8] | events.recover;
    end

    // lowest set bit moves into the queue, one per cycle
    always_comb begin
        grant = '0;
        enq_code = codes[0];
        for (int i = NE - 1; i >= 0; i--) begin
            if (pend_d[i]) begin
                grant = '0;
                grant[i] = 1'b1;
                enq_code = codes[i];
            end
        end
    end

    assign enq_valid = |pend_d;

    // staging flags; new arrivals are held until the queue has room
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend_q <= '0;
        end else if (ctrl.interface_clear_command) begin
            pend_q <= '0;
        end else if (enq_ready) begin
            pend_q <= pend_d & ~grant;
        end else begin
            pend_q <= pend_d;
        end
    end

    // power-up request is made exactly once per reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pwr_done_q <= 1'b0;
        end else begin
            pwr_done_q <= 1'b1;
        end
    end

    // queue keeps arrival order across polls
    srs_queue #(
        .DEPTH(DEPTH)
    ) u_queue (
        .core_clk(core_clk),
        .reset(reset),
        .flush(ctrl.interface_clear_command),
        .wr_valid(enq_valid && !ctrl.interface_clear_command),
        .wr_data(enq_code),
        .wr_ready(enq_ready),
        .rd_take(q_take),
        .rd_valid(q_valid),
        .rd_data(q_data)
    );

    // the head entry is the request on show; a poll retires it
    assign q_take = (state_q == SRS_ST_PEND) && ctrl.poll && !ctrl.interface_clear_command;

    // request state machine
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= SRS_ST_IDLE;
            cur_code_q <= `SRS_CODE_IDLE;
        end else if (ctrl.interface_clear_command) begin
            state_q <= SRS_ST_IDLE;
            cur_code_q <= `SRS_CODE_IDLE;
        end else begin
            case (state_q)
                SRS_ST_IDLE: begin
                    if (q_valid) begin
                        state_q <= SRS_ST_PEND;
                        cur_code_q <= q_data;
                    end
                end
                SRS_ST_PEND: begin
                    if (ctrl.poll) begin
                        state_q <= SRS_ST_POLLED;
                    end
                end
                SRS_ST_POLLED: begin
                    // one idle cycle so each request shows as a fresh edge
                    state_q <= SRS_ST_IDLE;
                end
                default: begin
                    state_q <= SRS_ST_IDLE;
                end
            endcase
        end
    end

    // request line follows the pending state
    always_ff @(posedge core_clk) begin
        if (reset) begin
            srq_q <= 1'b0;
        end else if (ctrl.interface_clear_command) begin
            srq_q <= 1'b0;
        end else if (state_q == SRS_ST_PEND && ctrl.poll) begin
            srq_q <= 1'b0;
        end else if (state_q == SRS_ST_IDLE && q_valid) begin
            srq_q <= 1'b1;
        end
    end

    // serial-poll answer, the only way a controller learns the cause
    always_ff @(posedge core_clk) begin
        if (reset) begin
            poll_byte_q <= `SRS_CODE_IDLE;
            poll_valid_q <= 1'b0;
        end else begin
            poll_valid_q <= ctrl.poll && !ctrl.interface_clear_command;
            // a poll refused by a clear leaves the last word standing
            if (ctrl.poll && !ctrl.interface_clear_command) begin
                if (state_q == SRS_ST_PEND) begin
                    poll_byte_q <= cur_code_q;
                    poll_byte_q[`SRS_RQS_BIT] <= 1'b1;
                end else begin
                    poll_byte_q <= idle_word;
                end
            end
        end
    end

    // sticky flag: a request was held back by a full queue
    always_ff @(posedge core_clk) begin
        if (reset || ctrl.interface_clear_command) begin
            overflow_q <= 1'b0;
        end else if (enq_valid && !enq_ready) begin
            overflow_q <= 1'b1;
        end
    end

    assign srq = srq_q;
    assign poll_byte = poll_byte_q;
    assign poll_valid = poll_valid_q;
    assign overflow = overflow_q;
endmodule
`default_nettype wire
